// ---- tb/link_ctrl_model.sv ----
`timescale 1ns/1ns
module link_ctrl_model (
  // clock
  input wire logic ref_clk,
  // register access
  output id_detect_pkg::reg_req_t req,
  input wire logic [7:0] rdata_r,
  input wire logic rvalid_r
);
  initial req = '0;

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a >= id_detect_pkg::ADDR_CONV_WR && a <= id_detect_pkg::ADDR_CONV_CLR)
      v[5] = 1'b0;
    @(posedge ref_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge ref_clk);
    req <= '0;
  endtask

  // read data lands one edge after the request edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '0;
    #1;
    d = rdata_r;
    ok = rvalid_r;
  endtask
endmodule

// ---- tb/tb_id_resistor_detect_regs.sv ----
`timescale 1ns/1ns
module tb_id_resistor_detect_regs;
  localparam int CONV_CYCLES = 20;
  logic ref_clk;
  logic rst;
  id_detect_pkg::reg_req_t req;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic id_floating;
  logic [2:0] adc_code;
  logic [1:0] tx_boost_sel;
  logic headset_audio_en;
  logic conv_busy;
  logic alt_int_r;
  int n_mismatch;
  int n_compared;
  int n_alt;
  int n_busy;
  int n_cyc;
  logic [7:0] v;
  logic ok;
  logic [7:0] en36;
  logic [5:0] ra[7] = '{6'h1D, 6'h20, 6'h21, 6'h31, 6'h33, 6'h36, 6'h3F};
  logic [7:0] hk[4] = '{8'h0A, 8'h0B, 8'hFA, 8'h05};
  logic [2:0] cd[3] = '{3'b101, 3'b111, 3'b001};

  id_resistor_detect_regs #(.CONV_CYCLES(CONV_CYCLES)) id_resistor_detect_regs_inst (
    .ref_clk(ref_clk), .rst(rst), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
    .id_floating(id_floating), .adc_code(adc_code), .tx_boost_sel(tx_boost_sel),
    .headset_audio_en(headset_audio_en), .conv_busy(conv_busy), .alt_int_r(alt_int_r)
  );
  link_ctrl_model link_ctrl_model_inst (
    .ref_clk(ref_clk), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r)
  );

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    n_cyc <= n_cyc + 1;
    if (alt_int_r === 1'b1)
      n_alt <= n_alt + 1;
    if (conv_busy === 1'b1)
      n_busy <= n_busy + 1;
    if (n_cyc == 5000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    link_ctrl_model_inst.rd(a, v, ok);
    chk("rvalid", 8'h01, {7'h00, ok});
    chk($sformatf("reg %h", a), e, v);
  endtask

  // id pin moves only a cycle after the request edge; pull-up taken as on
  task automatic id_to(input logic lvl);
    @(posedge ref_clk);
    id_floating <= lvl;
    repeat (2) @(posedge ref_clk);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    id_floating = 1'b0;
    adc_code = 3'b000;
    n_mismatch = 0;
    n_compared = 0;
    n_alt = 0;
    n_busy = 0;
    n_cyc = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ra[i])
      rchk(ra[i], 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++)
    begin
      link_ctrl_model_inst.wr(6'h31, {1'b1, i[1:0], 5'h1F});
      #1;
      chk("boost", {6'h00, i[1:0]}, {6'h00, tx_boost_sel});
      rchk(6'h31, {1'b0, i[1:0], 5'h00});
    end
    foreach (hk[i])
    begin
      link_ctrl_model_inst.wr(6'h33, hk[i]);
      #1;
      chk("headset", {7'h00, hk[i][3:0] == 4'b1010}, {7'h00, headset_audio_en});
      rchk(6'h33, {4'h0, hk[i][3:0]});
    end
    $display("test vendor fields done");
    link_ctrl_model_inst.wr(6'h21, 8'hFF);
    rchk(6'h21, 8'h00);
    link_ctrl_model_inst.wr(6'h1D, 8'hFF);
    rchk(6'h1D, 8'h23);
    link_ctrl_model_inst.wr(6'h1F, 8'h20);
    rchk(6'h1F, 8'h03);
    id_to(1'b1);
    rchk(6'h21, 8'h01);
    rchk(6'h21, 8'h00);
    link_ctrl_model_inst.wr(6'h1F, 8'h01);
    id_to(1'b0);
    rchk(6'h21, 8'h01);
    id_to(1'b1);
    rchk(6'h21, 8'h00);
    chk("alt count", 8'h02, n_alt[7:0]);
    $display("test id events done");
    // mode 0 no enable, mode 1 enable at 36h, mode 2 enable at 1Dh and trigger by write
    for (int m = 0; m < 3; m++)
    begin
      en36 = (m == 1) ? 8'h40 : 8'h00;
      link_ctrl_model_inst.wr(6'h1D, (m == 2) ? 8'h20 : 8'h00);
      link_ctrl_model_inst.wr(6'h36, en36);
      adc_code <= cd[m];
      n_busy = 0;
      n_alt = 0;
      link_ctrl_model_inst.wr((m == 2) ? 6'h36 : 6'h37, en36 | 8'h10);
      #1;
      chk("busy", 8'h01, {7'h00, conv_busy});
      for (int k = 0; k < 100 && conv_busy !== 1'b0; k++)
        @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      chk("busy cycles", CONV_CYCLES[7:0], n_busy[7:0]);
      rchk(6'h20, {2'b01, cd[m], 3'b001});
      rchk(6'h21, (m == 0) ? 8'h00 : 8'h08);
      chk("alt", (m == 0) ? 8'h00 : 8'h01, n_alt[7:0]);
      rchk(6'h37, en36 | 8'h08 | {5'h00, cd[m]});
      rchk(6'h38, en36 | {5'h00, cd[m]});
    end
    link_ctrl_model_inst.wr(6'h37, 8'h40);
    rchk(6'h36, 8'h41);
    link_ctrl_model_inst.wr(6'h38, 8'h40);
    rchk(6'h36, 8'h01);
    link_ctrl_model_inst.wr(6'h36, 8'h8F);
    rchk(6'h36, 8'h01);
    link_ctrl_model_inst.wr(6'h1E, 8'hFF);
    rchk(6'h1E, 8'h23);
    $display("test conversion done");
    conclude();
  end
endmodule

// ---- verilog/id_conv_timer.sv ----
`timescale 1ns/1ns
module id_conv_timer #(
  parameter int CONV_CYCLES = id_detect_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [2:0] code_in,
  // result
  output logic busy,
  output logic done_pulse,
  output logic [2:0] result_r
);

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_RUN = 2'b10
  } conv_state_t;

  conv_state_t state_r;
  logic [id_detect_pkg::CONV_CNT_W-1:0] cnt_r;
  localparam logic [id_detect_pkg::CONV_CNT_W-1:0] LAST_CNT =
    id_detect_pkg::CONV_CNT_W'(CONV_CYCLES - 1);

  assign busy = (state_r == CONV_RUN);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= CONV_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        CONV_IDLE:
        begin
          cnt_r <= '0;
          if (start)
            state_r <= CONV_RUN;
        end
        CONV_RUN:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == LAST_CNT)
            state_r <= CONV_IDLE;
        end
        default: state_r <= CONV_IDLE;
      endcase
    end
  end

  // the analogue code is sampled only at the end of the conversion window
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      done_pulse <= 1'b0;
      result_r <= id_detect_pkg::RESULT_RESET;
    end
    else
    begin
      done_pulse <= busy && (cnt_r == LAST_CNT);
      if (busy && (cnt_r == LAST_CNT))
        result_r <= code_in;
    end
  end

  conv_length_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(busy) |-> busy [*8])
    else $error("conversion ended too early");

endmodule

// ---- verilog/id_detect_pkg.sv ----
package id_detect_pkg;

  // register addresses on the 6-bit ulpi register space
  localparam logic [5:0] ADDR_IRQ_EN_WR = 6'h1D;
  localparam logic [5:0] ADDR_IRQ_EN_SET = 6'h1E;
  localparam logic [5:0] ADDR_IRQ_EN_CLR = 6'h1F;
  localparam logic [5:0] ADDR_CARKIT_STATUS = 6'h20;
  localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;
  localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_HI = 6'h3F;
  localparam logic [5:0] ADDR_TX_AMPLITUDE = 6'h31;
  localparam logic [5:0] ADDR_HEADSET_KEY = 6'h33;
  localparam logic [5:0] ADDR_CONV_WR = 6'h36;
  localparam logic [5:0] ADDR_CONV_SET = 6'h37;
  localparam logic [5:0] ADDR_CONV_CLR = 6'h38;

  // writable bits per register
  localparam logic [7:0] IRQ_EN_MASK = 8'h23;
  localparam logic [7:0] TX_AMPLITUDE_MASK = 8'h60;
  localparam logic [7:0] HEADSET_KEY_MASK = 8'h0F;
  localparam logic [7:0] CONV_CTRL_MASK = 8'h70;

  // field positions
  localparam int IRQ_EN_RISE_BIT = 0;
  localparam int IRQ_EN_FALL_BIT = 1;
  localparam int IRQ_EN_RID_BIT = 5;
  localparam int LATCH_ID_BIT = 0;
  localparam int LATCH_RID_BIT = 3;
  localparam int CONV_TRIGGER_BIT = 4;
  localparam int CONV_IRQ_EN_BIT = 6;
  localparam int BOOST_LSB = 5;

  localparam logic [3:0] HEADSET_UNLOCK_KEY = 4'b1010;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] RESULT_RESET = 3'b000;

  // conversion time: 282 us at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int CONV_TIME_US = 282;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int CONV_CNT_W = 16;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_SET = 2'b01,
    OP_CLEAR = 2'b10
  } wr_op_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ---- verilog/id_resistor_detect_regs.sv ----
`timescale 1ns/1ns
module id_resistor_detect_regs #(
  parameter int CONV_CYCLES = id_detect_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ulpi register access, decoded by the link front end
  input wire id_detect_pkg::reg_req_t req,
  output logic [7:0] rdata_r,
  output logic rvalid_r,
  // analogue side
  input wire logic id_floating,
  input wire logic [2:0] adc_code,
  // controls and status toward the phy
  output logic [1:0] tx_boost_sel,
  output logic headset_audio_en,
  output logic conv_busy,
  output logic alt_int_r
);

  logic [7:0] irq_en_r;
  logic [7:0] latch_r;
  logic [7:0] boost_r;
  logic [7:0] headset_r;
  logic [7:0] conv_r;
  logic [7:0] conv_nxt;
  logic done_r;
  logic id_prev_r;
  logic conv_done;
  logic [2:0] result_code;
  logic rd_latch;
  logic rd_conv;
  logic rid_en;
  logic id_event;
  logic rid_event;
  logic start_conv;

  function automatic logic [7:0] apply_op(
    input logic [7:0] old_v,
    input logic [7:0] data,
    input logic [7:0] mask,
    input id_detect_pkg::wr_op_t op
  );
    logic [7:0] r;
    r = old_v;
    unique case (op)
      id_detect_pkg::OP_WRITE: r = data & mask;
      id_detect_pkg::OP_SET: r = (old_v | data) & mask;
      id_detect_pkg::OP_CLEAR: r = old_v & ~data & mask;
      default: r = old_v;
    endcase
    return r;
  endfunction

  function automatic logic in_range(
    input logic [5:0] a,
    input logic [5:0] lo,
    input logic [5:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction

  assign rd_latch = req.rd && (req.addr == id_detect_pkg::ADDR_EVENT_LATCH);
  assign rd_conv = req.rd &&
    in_range(req.addr, id_detect_pkg::ADDR_CONV_WR, id_detect_pkg::ADDR_CONV_CLR);
  assign rid_en = irq_en_r[id_detect_pkg::IRQ_EN_RID_BIT] |
    conv_r[id_detect_pkg::CONV_IRQ_EN_BIT];
  // pull-up is the link's job; floating level is trusted as given
  assign id_event = (id_floating && !id_prev_r && irq_en_r[id_detect_pkg::IRQ_EN_RISE_BIT]) ||
    (!id_floating && id_prev_r && irq_en_r[id_detect_pkg::IRQ_EN_FALL_BIT]);
  assign rid_event = conv_done && !done_r && rid_en;

  // carkit interrupt enable, write/set/clear at three addresses
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_en_r <= id_detect_pkg::REG_RESET;
    else if (req.wr)
    begin
      unique case (req.addr)
        id_detect_pkg::ADDR_IRQ_EN_WR:
          irq_en_r <= apply_op(irq_en_r, req.wdata, id_detect_pkg::IRQ_EN_MASK,
            id_detect_pkg::OP_WRITE);
        id_detect_pkg::ADDR_IRQ_EN_SET:
          irq_en_r <= apply_op(irq_en_r, req.wdata, id_detect_pkg::IRQ_EN_MASK,
            id_detect_pkg::OP_SET);
        id_detect_pkg::ADDR_IRQ_EN_CLR:
          irq_en_r <= apply_op(irq_en_r, req.wdata, id_detect_pkg::IRQ_EN_MASK,
            id_detect_pkg::OP_CLEAR);
        default: irq_en_r <= irq_en_r;
      endcase
    end
  end

  // vendor read/write registers, reserved bits masked off
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      boost_r <= id_detect_pkg::REG_RESET;
      headset_r <= id_detect_pkg::REG_RESET;
    end
    else if (req.wr)
    begin
      if (req.addr == id_detect_pkg::ADDR_TX_AMPLITUDE)
        boost_r <= req.wdata & id_detect_pkg::TX_AMPLITUDE_MASK;
      if (req.addr == id_detect_pkg::ADDR_HEADSET_KEY)
        headset_r <= req.wdata & id_detect_pkg::HEADSET_KEY_MASK;
    end
  end

  assign tx_boost_sel = boost_r[id_detect_pkg::BOOST_LSB +: 2];
  assign headset_audio_en = (headset_r[3:0] == id_detect_pkg::HEADSET_UNLOCK_KEY);

  always_comb
  begin
    conv_nxt = conv_r;
    if (req.wr)
    begin
      unique case (req.addr)
        id_detect_pkg::ADDR_CONV_WR:
          conv_nxt = apply_op(conv_r, req.wdata, id_detect_pkg::CONV_CTRL_MASK,
            id_detect_pkg::OP_WRITE);
        id_detect_pkg::ADDR_CONV_SET:
          conv_nxt = apply_op(conv_r, req.wdata, id_detect_pkg::CONV_CTRL_MASK,
            id_detect_pkg::OP_SET);
        id_detect_pkg::ADDR_CONV_CLR:
          conv_nxt = apply_op(conv_r, req.wdata, id_detect_pkg::CONV_CTRL_MASK,
            id_detect_pkg::OP_CLEAR);
        default: conv_nxt = conv_r;
      endcase
    end
    // completion wins over a same-cycle write of the trigger
    if (conv_done)
      conv_nxt[id_detect_pkg::CONV_TRIGGER_BIT] = 1'b0;
  end

  // a clear of the trigger does not abort a running conversion
  assign start_conv = !conv_r[id_detect_pkg::CONV_TRIGGER_BIT] &&
    conv_nxt[id_detect_pkg::CONV_TRIGGER_BIT] && !conv_busy;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      conv_r <= id_detect_pkg::REG_RESET;
    else
      conv_r <= conv_nxt;
  end

  id_conv_timer #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(start_conv),
    .code_in(adc_code),
    .busy(conv_busy),
    .done_pulse(conv_done),
    .result_r(result_code)
  );

  // completion flag: set wins over the read-clear; status read leaves it alone
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      done_r <= 1'b0;
    else if (conv_done)
      done_r <= 1'b1;
    else if (rd_conv)
      done_r <= 1'b0;
  end

  // event latch: bits returned by a read are cleared, new events still land
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      latch_r <= id_detect_pkg::REG_RESET;
      id_prev_r <= 1'b0;
    end
    else
    begin
      id_prev_r <= id_floating;
      if (rd_latch)
        latch_r <= id_detect_pkg::REG_RESET;
      if (id_event)
        latch_r[id_detect_pkg::LATCH_ID_BIT] <= 1'b1;
      if (rid_event)
        latch_r[id_detect_pkg::LATCH_RID_BIT] <= 1'b1;
    end
  end

  // one-cycle request for alt_int in the next rx command
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      alt_int_r <= 1'b0;
    else
      alt_int_r <= id_event || rid_event;
  end

  // read data, one cycle after the request; unmapped reads return zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= id_detect_pkg::REG_RESET;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= req.rd;
      rdata_r <= id_detect_pkg::REG_RESET;
      if (req.rd)
      begin
        if (in_range(req.addr, id_detect_pkg::ADDR_IRQ_EN_WR, id_detect_pkg::ADDR_IRQ_EN_CLR))
          rdata_r <= irq_en_r;
        else if (req.addr == id_detect_pkg::ADDR_CARKIT_STATUS)
          rdata_r <= {1'b0, done_r, result_code, 2'b00, id_floating};
        else if (rd_latch)
          rdata_r <= {4'h0, latch_r[3], 2'b00, latch_r[0]};
        else if (req.addr == id_detect_pkg::ADDR_TX_AMPLITUDE)
          rdata_r <= boost_r;
        else if (req.addr == id_detect_pkg::ADDR_HEADSET_KEY)
          rdata_r <= headset_r;
        else if (rd_conv)
          rdata_r <= {1'b0, conv_r[6:4], done_r, result_code};
      end
    end
  end

  latch_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_latch && !id_event && !rid_event |=> latch_r == 8'h00)
    else $error("latch not cleared by read");

  latch_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_latch |=> (rdata_r[7:4] == 4'h0) && (rdata_r[2:1] == 2'b00))
    else $error("reserved latch bits not zero");

  id_event_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(id_floating) && irq_en_r[0] |=> latch_r[0] && alt_int_r)
    else $error("id open rise not latched");

  id_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(id_floating) && irq_en_r[id_detect_pkg::IRQ_EN_FALL_BIT]
      |=> latch_r[id_detect_pkg::LATCH_ID_BIT] && alt_int_r)
    else $error("id open fall not latched");

  rid_event_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done && !done_r && rid_en |=> latch_r[3] && alt_int_r)
    else $error("measure event not latched");

  boost_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    req.wr && req.addr == 6'h31 |=> tx_boost_sel == $past(req.wdata[6:5]) && boost_r[4:0] == 5'h0)
    else $error("boost field not taken");

  headset_key_a: assert property (@(posedge ref_clk) disable iff (rst)
    req.wr && req.addr == 6'h33 && req.wdata[3:0] != 4'b1010 |=> !headset_audio_en)
    else $error("headset enabled without key");

  done_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_conv && !conv_done |=> !done_r)
    else $error("complete not cleared by vendor read");

  status_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    req.rd && req.addr == 6'h20 && done_r |=> done_r)
    else $error("status read cleared complete");

  trigger_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done |=> !conv_r[4] && done_r)
    else $error("trigger not self-cleared");

endmodule
